// File: rtl/hv_prog_defines.vh
`ifndef HV_PROG_DEFINES_VH
`define HV_PROG_DEFINES_VH
// Action selector codes
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
`define ACT_IDLE 2'h3
// Command bytes
`define CMD_NOP 8'h00
`define CMD_CHIP_ERASE 8'h80
`define CMD_WR_FUSE 8'h40
`define CMD_WR_LOCK 8'h20
`define CMD_WR_FLASH 8'h10
`define CMD_WR_EEPROM 8'h11
`define CMD_RD_SIG 8'h08
`define CMD_RD_FUSE_LOCK 8'h04
`define CMD_RD_FLASH 8'h02
`define CMD_RD_EEPROM 8'h03
// Memory geometry
`define FLASH_AW 13
`define FLASH_WORDS 8192
`define PAGE_WORD_BITS 6
`define PAGE_WORDS 64
`define EE_AW 9
`define EE_BYTES 512
`define EE_PAGE_BITS 2
`define EE_PAGE_BYTES 4
// Fuse and lock reset values (arbitrary neutral defaults)
`define FUSE_LO_RST 8'hFF
`define FUSE_HI_RST 8'hFF
`define FUSE_EXT_RST 8'hFF
`define LOCK_RST 8'hFF
// Erase-keep fuse position in the high fuse byte
`define ERASE_KEEP_BIT 3
// Signature bytes (arbitrary values)
`define SIG_BYTE0 8'h5A
`define SIG_BYTE1 8'hA5
`define SIG_BYTE2 8'h3C
`define CAL_BYTE 8'h80
// Busy timing: program/erase time in ns and cycles at 4 ns
`define CLK_PERIOD_NS 4
`define BUSY_TIME_NS 4000
`define BUSY_CYCLES ((`BUSY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: rtl/hv_prog_port.v
`timescale 1ns/1ns
`include "hv_prog_defines.vh"
module hv_prog_port
(
  input wire sys_clk_in,
  input wire reset_n_in,
  input wire hv_reset_in,
  input wire [3:0] entry_pattern_in,
  input wire load_strobe_in,
  input wire page_latch_strobe_in,
  input wire write_strobe_n_in,
  input wire output_enable_n_in,
  input wire action_sel_hi_in,
  input wire action_sel_lo_in,
  input wire byte_select_in,
  input wire byte_select_ext_in,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe_n_out,
  output reg ready_busy_out,
  output reg prog_mode_out
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ERASE = 2'h1;
  localparam [1:0] ST_PROG = 2'h2;
  localparam [1:0] ST_CLEAR = 2'h3;
  localparam [31:0] BUSY_N = `BUSY_CYCLES;
  // Idle pin levels, so that no false strobe edge follows reset
  localparam [20:0] PINS_IDLE = 21'h003C00;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Three stages per pin; a change is seen once stages two and three agree
  wire [20:0] pins_raw;
  reg [20:0] s1_q;
  reg [20:0] s2_q;
  reg [20:0] s3_q;
  reg [20:0] pins_q;
  assign pins_raw = {hv_reset_in, entry_pattern_in, load_strobe_in, page_latch_strobe_in,
    write_strobe_n_in, output_enable_n_in, action_sel_hi_in, action_sel_lo_in,
    byte_select_in, byte_select_ext_in, data_in};

  // Sync chain plus agreement filter
  always @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s1_q <= PINS_IDLE;
      s2_q <= PINS_IDLE;
      s3_q <= PINS_IDLE;
      pins_q <= PINS_IDLE;
    end
    else
    begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pins_q <= (pins_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q)); // Hold while stages differ
    end
  end

  wire hv_s = pins_q[20];
  wire [3:0] entry_s = pins_q[19:16];
  wire load_s = pins_q[15];
  wire latch_s = pins_q[14];
  wire wr_n_s = pins_q[13];
  wire oe_n_s = pins_q[12];
  wire [1:0] act_s = pins_q[11:10];
  wire bs1_s = pins_q[9];
  wire bs2_s = pins_q[8];
  wire [7:0] dat_s = pins_q[7:0];

  // ------------------------------------------------------------------
  // Strobe edges and state
  // ------------------------------------------------------------------
  reg load_d1_q;
  reg latch_d1_q;
  reg wr_d1_q;
  reg hv_d1_q;
  reg [7:0] cmd_q;
  reg [7:0] addr_lo_q;
  reg [7:0] addr_hi_q;
  reg [7:0] dlo_q;
  reg [7:0] dhi_q;
  reg [1:0] state_q;
  reg [31:0] cnt_q;
  reg [`FLASH_AW-1:0] wipe_q;
  reg [7:0] fuse_lo_q;
  reg [7:0] fuse_hi_q;
  reg [7:0] fuse_ext_q;
  reg [7:0] lock_q;
  reg [15:0] flash_mem [0:`FLASH_WORDS-1];
  reg [7:0] ee_mem [0:`EE_BYTES-1];
  reg [15:0] page_buf [0:`PAGE_WORDS-1];
  reg [7:0] ee_buf [0:`EE_PAGE_BYTES-1];
  reg [`PAGE_WORDS-1:0] page_vld_q;
  reg [`EE_PAGE_BYTES-1:0] ee_vld_q;
  reg [`PAGE_WORD_BITS:0] pi_q;

  wire load_rise = load_s & ~load_d1_q;
  wire latch_rise = latch_s & ~latch_d1_q;
  wire wr_fall = ~wr_n_s & wr_d1_q;
  wire busy = (state_q != ST_IDLE);
  wire [15:0] addr = {addr_hi_q, addr_lo_q};
  wire [`FLASH_AW-1:0] faddr = addr[`FLASH_AW-1:0];
  wire [`EE_AW-1:0] eaddr = addr[`EE_AW-1:0];
  wire [`PAGE_WORD_BITS-1:0] widx = addr_lo_q[`PAGE_WORD_BITS-1:0];
  wire [`EE_PAGE_BITS-1:0] eidx = addr_lo_q[`EE_PAGE_BITS-1:0];
  // Page number uses upper low-byte bits plus the low high-byte bits (five for flash, one for EEPROM)
  wire [`FLASH_AW-1:0] fpage = {faddr[`FLASH_AW-1:`PAGE_WORD_BITS],
    {`PAGE_WORD_BITS{1'b0}}};
  wire [`EE_AW-1:0] epage = {eaddr[`EE_AW-1:`EE_PAGE_BITS], {`EE_PAGE_BITS{1'b0}}};
  wire keep_ee = ~fuse_hi_q[`ERASE_KEEP_BIT];

  // ------------------------------------------------------------------
  // Mode entry and command engine
  // ------------------------------------------------------------------
  // Mode entry on high-voltage rise with all-zero pattern; exit on drop
  always @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      load_d1_q <= 1'b0;
      latch_d1_q <= 1'b0;
      wr_d1_q <= 1'b1;
      hv_d1_q <= 1'b0;
      prog_mode_out <= 1'b0;
      cmd_q <= `CMD_NOP;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      dlo_q <= 8'hFF;
      dhi_q <= 8'hFF;
      state_q <= ST_IDLE;
      cnt_q <= 32'h00000000;
      wipe_q <= {`FLASH_AW{1'b0}};
      fuse_lo_q <= `FUSE_LO_RST;
      fuse_hi_q <= `FUSE_HI_RST;
      fuse_ext_q <= `FUSE_EXT_RST;
      lock_q <= `LOCK_RST;
      page_vld_q <= {`PAGE_WORDS{1'b0}};
      ee_vld_q <= {`EE_PAGE_BYTES{1'b0}};
      pi_q <= {(`PAGE_WORD_BITS+1){1'b0}};
      ready_busy_out <= 1'b1;
    end
    else
    begin
      load_d1_q <= load_s;
      latch_d1_q <= latch_s;
      wr_d1_q <= wr_n_s;
      hv_d1_q <= hv_s;
      if (hv_s & ~hv_d1_q & (entry_s == 4'h0))
        prog_mode_out <= 1'b1;
      else if (~hv_s)
        prog_mode_out <= 1'b0;
      ready_busy_out <= ~busy;
      case (state_q)
        ST_IDLE:
        begin
          if (prog_mode_out & load_rise)
          begin
            case (act_s)
              `ACT_ADDR:
                if (bs1_s) addr_hi_q <= dat_s; else addr_lo_q <= dat_s;
              `ACT_DATA:
                if (bs1_s) dhi_q <= dat_s; else dlo_q <= dat_s;
              `ACT_CMD:
              begin
                cmd_q <= dat_s;
                if (dat_s == `CMD_NOP)
                begin
                  page_vld_q <= {`PAGE_WORDS{1'b0}};
                  ee_vld_q <= {`EE_PAGE_BYTES{1'b0}};
                end
              end
              default: ; // Idle selector: no action
            endcase
          end
          // Page latch: word into flash buffer, byte into EEPROM buffer
          if (prog_mode_out & latch_rise)
          begin
            if (cmd_q == `CMD_WR_FLASH && bs1_s)
            begin
              page_buf[widx] <= {dhi_q, dlo_q};
              page_vld_q[widx] <= 1'b1;
            end
            else if (cmd_q == `CMD_WR_EEPROM)
            begin
              ee_buf[eidx] <= dlo_q;
              ee_vld_q[eidx] <= 1'b1;
            end
          end
          // Write strobe starts the operation chosen by the command
          if (prog_mode_out & wr_fall)
          begin
            cnt_q <= BUSY_N;
            case (cmd_q)
              `CMD_CHIP_ERASE:
              begin
                state_q <= ST_ERASE;
                wipe_q <= {`FLASH_AW{1'b0}};
              end
              `CMD_WR_FLASH, `CMD_WR_EEPROM:
              begin
                state_q <= ST_PROG;
                pi_q <= {(`PAGE_WORD_BITS+1){1'b0}};
              end
              `CMD_WR_FUSE:
              begin
                state_q <= ST_CLEAR;
                if (bs1_s & ~bs2_s) fuse_hi_q <= dlo_q;
                else if (~bs1_s & bs2_s) fuse_ext_q <= dlo_q;
                else fuse_lo_q <= dlo_q;
              end
              `CMD_WR_LOCK:
              begin
                state_q <= ST_CLEAR;
                lock_q <= lock_q & dlo_q;
              end
              default: cnt_q <= 32'h00000000;
            endcase
          end
        end
        ST_ERASE:
        begin
          // Wipe one flash word per cycle; EEPROM bytes too in the first EE_BYTES cycles unless erase-keep is programmed
          flash_mem[wipe_q] <= 16'hFFFF;
          if (!keep_ee && wipe_q < `EE_BYTES)
            ee_mem[wipe_q[`EE_AW-1:0]] <= 8'hFF;
          wipe_q <= wipe_q + {{(`FLASH_AW-1){1'b0}}, 1'b1};
          if (wipe_q == `FLASH_WORDS-1)
          begin
            lock_q <= 8'hFF; // Locks cleared in the same cycle as the last flash word
            state_q <= ST_CLEAR;
          end
        end
        ST_PROG:
        begin
          // Copy the latched buffer slots into the addressed page
          if (cmd_q == `CMD_WR_FLASH)
          begin
            if (page_vld_q[pi_q[`PAGE_WORD_BITS-1:0]])
              flash_mem[fpage | pi_q[`PAGE_WORD_BITS-1:0]] <=
                page_buf[pi_q[`PAGE_WORD_BITS-1:0]];
          end
          else if (pi_q < `EE_PAGE_BYTES && ee_vld_q[pi_q[`EE_PAGE_BITS-1:0]])
            ee_mem[epage | pi_q[`EE_PAGE_BITS-1:0]] <= ee_buf[pi_q[`EE_PAGE_BITS-1:0]];
          pi_q <= pi_q + {{`PAGE_WORD_BITS{1'b0}}, 1'b1};
          if (pi_q == `PAGE_WORDS-1)
          begin
            page_vld_q <= {`PAGE_WORDS{1'b0}};
            ee_vld_q <= {`EE_PAGE_BYTES{1'b0}};
            state_q <= ST_CLEAR;
          end
        end
        ST_CLEAR:
        begin
          // Hold busy for the self-timed program interval
          if (cnt_q != 32'h00000000)
            cnt_q <= cnt_q - 32'h00000001;
          else
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
      if (~hv_s)
        state_q <= ST_IDLE;
    end
  end

  // ------------------------------------------------------------------
  // Read-back mux
  // ------------------------------------------------------------------
  reg [7:0] rd_d;
  reg [15:0] fw;
  // Selected byte depends on command and byte selects
  always @*
  begin
    fw = flash_mem[faddr];
    rd_d = 8'hFF;
    case (cmd_q)
      `CMD_RD_FLASH: rd_d = bs1_s ? fw[15:8] : fw[7:0];
      `CMD_RD_EEPROM: rd_d = ee_mem[eaddr];
      `CMD_RD_SIG:
        if (bs1_s) rd_d = `CAL_BYTE;
        else if (addr_lo_q == 8'h00) rd_d = `SIG_BYTE0;
        else if (addr_lo_q == 8'h01) rd_d = `SIG_BYTE1;
        else if (addr_lo_q == 8'h02) rd_d = `SIG_BYTE2;
        else rd_d = 8'hFF;
      `CMD_RD_FUSE_LOCK:
        case ({bs2_s, bs1_s})
          2'h0: rd_d = fuse_lo_q;
          2'h3: rd_d = fuse_hi_q;
          2'h2: rd_d = fuse_ext_q;
          default: rd_d = lock_q;
        endcase
      default: rd_d = 8'hFF;
    endcase
  end

  // Bus driven only in mode, idle, with output enable low
  always @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      data_out <= 8'hFF;
      data_oe_n_out <= 1'b1;
    end
    else
    begin
      data_out <= rd_d;
      data_oe_n_out <= ~(prog_mode_out & ~oe_n_s & ~busy);
    end
  end

endmodule // hv_prog_port

// File: sim/hv_prog_port_sva.sv
`timescale 1ns/1ns
module hv_prog_port_chk
(
  input wire sys_clk_in,
  input wire reset_n_in,
  input wire hv_reset_in,
  input wire write_strobe_n_in,
  input wire output_enable_n_in,
  input wire data_oe_n_out,
  input wire ready_busy_out,
  input wire prog_mode_out
);
  localparam int BUSY_MAX = 9200;
  int busy_cnt;
  // Busy length; on an overrun the programmer stops waiting for ready after 20000 cycles
  always @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      busy_cnt <= 0;
    else if (!ready_busy_out)
      busy_cnt <= busy_cnt + 1;
    else
      busy_cnt <= 0;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_busy_start; $fell(ready_busy_out); endsequence
  sequence s_write_quiet; (ready_busy_out && write_strobe_n_in) [*8]; endsequence
  property p_busy_cause; s_busy_start |-> !$past(write_strobe_n_in, 3); endproperty
  property p_busy_min; s_busy_start |-> !ready_busy_out [*8]; endproperty
  property p_busy_max; busy_cnt < BUSY_MAX; endproperty
  property p_no_spurious; s_write_quiet |=> ready_busy_out; endproperty
  property p_mode_exit; (!hv_reset_in) [*8] |-> !prog_mode_out; endproperty
  property p_mode_cause; $rose(prog_mode_out) |-> $past(hv_reset_in, 3); endproperty
  property p_oe_cause; $fell(data_oe_n_out) |-> !$past(output_enable_n_in, 3); endproperty
  property p_oe_off; output_enable_n_in [*8] |-> data_oe_n_out; endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  a_no_spurious: assert property (p_no_spurious) else $error("stray busy");
  a_mode_exit: assert property (p_mode_exit) else $error("mode kept");
  a_mode_cause: assert property (p_mode_cause) else $error("mode without hv");
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven unasked");
  a_oe_off: assert property (p_oe_off) else $error("bus not released");
endmodule // hv_prog_port_chk

// File: sim/hv_programmer.sv
`timescale 1ns/1ns
module hv_programmer
#(
  parameter int HOLD_CYC = 2500,
  parameter int SETTLE_CYC = 75000
)
(
  input wire sys_clk_in,
  input wire ready_busy_in,
  input wire [7:0] bus_in,
  output reg hv_out,
  output reg [3:0] pat_out,
  output reg ld_out,
  output reg pl_out,
  output reg wr_n_out,
  output reg oe_n_out,
  output reg [1:0] act_out,
  output reg bs1_out,
  output reg bs2_out,
  output reg [7:0] dat_out,
  output reg drv_out
);
  // ----------------------------------------
  // Pin sequencing
  // ----------------------------------------
  // Idle levels: strobes inactive, entry pattern at zero
  initial
  begin
    hv_out = 1'b0;
    pat_out = 4'h0;
    ld_out = 1'b0;
    pl_out = 1'b0;
    wr_n_out = 1'b1;
    oe_n_out = 1'b1;
    act_out = 2'h3;
    bs1_out = 1'b0;
    bs2_out = 1'b0;
    dat_out = 8'h00;
    drv_out = 1'b1;
  end
  // Every level stands 8 clocks, above the synchroniser minimum of the port
  task automatic step;
    repeat (8) @(negedge sys_clk_in);
  endtask
  // Settle wait is the full start-up time; it dominates the run length
  task automatic enter;
    hv_out = 1'b1;
    repeat (HOLD_CYC) @(negedge sys_clk_in);
    pat_out = 4'hA;
    repeat (SETTLE_CYC) @(negedge sys_clk_in);
  endtask
  task automatic leave;
    hv_out = 1'b0;
    step;
  endtask
  // Selector goes back to idle so a stray edge does nothing
  task automatic ld(input logic [1:0] act, input logic b1, input logic [7:0] d);
    act_out = act;
    bs1_out = b1;
    dat_out = d;
    step;
    ld_out = 1'b1;
    step;
    ld_out = 1'b0;
    act_out = 2'h3;
    step;
  endtask
  task automatic lt;
    bs1_out = 1'b1;
    step;
    pl_out = 1'b1;
    step;
    pl_out = 1'b0;
    step;
  endtask
  // Write pulse, then no new command until ready returns
  task automatic wr(input logic b1, input logic b2, output logic seen, output logic done);
    bs1_out = b1;
    bs2_out = b2;
    step;
    wr_n_out = 1'b0;
    step;
    wr_n_out = 1'b1;
    bs1_out = 1'b0;
    bs2_out = 1'b0;
    step;
    seen = ~ready_busy_in;
    done = 1'b0;
    for (int i = 0; i < 20000 && !done; i++)
    begin
      @(negedge sys_clk_in);
      done = ready_busy_in;
    end
  endtask
  // Bus is released first so the device alone drives it
  task automatic rd(input logic b1, input logic b2, output logic [7:0] v);
    bs1_out = b1;
    bs2_out = b2;
    drv_out = 1'b0;
    oe_n_out = 1'b0;
    step;
    v = bus_in;
    oe_n_out = 1'b1;
    bs2_out = 1'b0;
    step;
    drv_out = 1'b1;
    @(negedge sys_clk_in);
  endtask
endmodule // hv_programmer

// File: sim/tb_top.sv
`timescale 1ns/1ns
`include "hv_prog_defines.vh"
module tb_top;
  logic sys_clk_in;
  logic reset_n_in;
  int bad_count;
  int checked;
  wire hv, ld, pl, wr_n, oe_n, bs1, bs2, drv;
  wire [3:0] pat;
  wire [1:0] act;
  wire [7:0] dat, bus, data_out;
  wire data_oe_n_out, ready_busy_out, prog_mode_out;
  // Bus level: device when enabled, else the programmer or a flipped residue
  assign bus = !data_oe_n_out ? data_out : (drv ? dat : ~dat);
  hv_programmer pg
  (
    .sys_clk_in(sys_clk_in), .ready_busy_in(ready_busy_out), .bus_in(bus),
    .hv_out(hv), .pat_out(pat), .ld_out(ld), .pl_out(pl), .wr_n_out(wr_n),
    .oe_n_out(oe_n), .act_out(act), .bs1_out(bs1), .bs2_out(bs2),
    .dat_out(dat), .drv_out(drv)
  );
  hv_prog_port dut
  (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .hv_reset_in(hv),
    .entry_pattern_in(pat), .load_strobe_in(ld), .page_latch_strobe_in(pl),
    .write_strobe_n_in(wr_n), .output_enable_n_in(oe_n), .action_sel_hi_in(act[1]),
    .action_sel_lo_in(act[0]), .byte_select_in(bs1), .byte_select_ext_in(bs2),
    .data_in(bus), .data_out(data_out), .data_oe_n_out(data_oe_n_out),
    .ready_busy_out(ready_busy_out), .prog_mode_out(prog_mode_out)
  );
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  task automatic conclude;
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    pg.ld(`ACT_CMD, 1'b0, c);
  endtask
  task automatic adr(input logic b1, input logic [7:0] d);
    pg.ld(`ACT_ADDR, b1, d);
  endtask
  task automatic dta(input logic b1, input logic [7:0] d);
    pg.ld(`ACT_DATA, b1, d);
  endtask
  task automatic wr_chk(input logic b1, input logic b2);
    logic s;
    logic d;
    pg.wr(b1, b2, s, d);
    chk({6'h0, s, d}, 8'h03);
  endtask
  task automatic rd_chk(input logic b1, input logic b2, input logic [7:0] exp);
    logic [7:0] v;
    pg.rd(b1, b2, v);
    chk(v, exp);
  endtask
  // Fuse, lock and one EEPROM byte; erase-keep fuse bit 3 programmed
  task automatic t_fuse_lock;
    cmd(`CMD_WR_FUSE);
    dta(1'b0, 8'hF7);
    wr_chk(1'b1, 1'b0);
    cmd(`CMD_WR_LOCK);
    dta(1'b0, 8'hFC);
    wr_chk(1'b0, 1'b0);
    cmd(`CMD_RD_FUSE_LOCK);
    rd_chk(1'b1, 1'b1, 8'hF7);
    rd_chk(1'b1, 1'b0, 8'hFC);
    rd_chk(1'b0, 1'b0, `FUSE_LO_RST);
    rd_chk(1'b0, 1'b1, `FUSE_EXT_RST);
    cmd(`CMD_WR_EEPROM);
    adr(1'b1, 8'h00);
    adr(1'b0, 8'h02);
    dta(1'b0, 8'h5C);
    pg.lt;
    wr_chk(1'b0, 1'b0);
  endtask
  // Erase before any reprogramming
  task automatic t_erase;
    cmd(`CMD_CHIP_ERASE);
    // A stray address load while busy must leave the retained address alone
    fork
      wr_chk(1'b0, 1'b0);
      begin
        repeat (40) @(negedge sys_clk_in);
        adr(1'b0, 8'h07);
      end
    join
    cmd(`CMD_RD_FUSE_LOCK);
    rd_chk(1'b1, 1'b0, 8'hFF);
    rd_chk(1'b1, 1'b1, 8'hF7);
    cmd(`CMD_RD_EEPROM);
    rd_chk(1'b0, 1'b0, 8'h5C);
  endtask
  // Two words in page 0; idle load of 00 must not become a no-op command
  // Words left at FFh after the erase are never written
  task automatic t_flash;
    cmd(`CMD_WR_FLASH);
    // A word latched before a no-op command must never reach flash
    adr(1'b0, 8'h07);
    pg.lt;
    cmd(`CMD_NOP);
    cmd(`CMD_WR_FLASH);
    adr(1'b0, 8'h05);
    dta(1'b0, 8'hA1);
    dta(1'b1, 8'hB2);
    pg.lt;
    adr(1'b0, 8'h06);
    dta(1'b0, 8'h11);
    dta(1'b1, 8'h22);
    pg.lt;
    adr(1'b1, 8'h00);
    pg.ld(`ACT_IDLE, 1'b0, 8'h00);
    wr_chk(1'b0, 1'b0);
    cmd(`CMD_RD_FLASH);
    adr(1'b0, 8'h05);
    rd_chk(1'b0, 1'b0, 8'hA1);
    rd_chk(1'b1, 1'b0, 8'hB2);
    adr(1'b0, 8'h06);
    rd_chk(1'b1, 1'b0, 8'h22);
    adr(1'b0, 8'h45);
    rd_chk(1'b0, 1'b0, 8'hFF);
    adr(1'b0, 8'h07);
    rd_chk(1'b0, 1'b0, 8'hFF);
  endtask
  task automatic t_sig;
    cmd(`CMD_RD_SIG);
    adr(1'b0, 8'h00);
    rd_chk(1'b0, 1'b0, `SIG_BYTE0);
    rd_chk(1'b1, 1'b0, `CAL_BYTE);
    adr(1'b0, 8'h01);
    rd_chk(1'b0, 1'b0, `SIG_BYTE1);
    adr(1'b0, 8'h02);
    rd_chk(1'b0, 1'b0, `SIG_BYTE2);
  endtask
  // Watchdog: a clean run takes about 92k cycles, most of it the entry wait
  initial
  begin
    #396000;
    bad_count++;
    conclude;
  end
  initial
  begin
    bad_count = 0;
    checked = 0;
    reset_n_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    repeat (8) @(negedge sys_clk_in);
    chk({7'h0, prog_mode_out}, 8'h00);
    pg.enter;
    chk({7'h0, prog_mode_out}, 8'h01);
    t_fuse_lock;
    t_erase;
    t_flash;
    t_sig;
    pg.leave;
    chk({7'h0, prog_mode_out}, 8'h00);
    conclude;
  end
endmodule // tb_top
bind hv_prog_port hv_prog_port_chk chk (.sys_clk_in, .reset_n_in, .hv_reset_in,
  .write_strobe_n_in, .output_enable_n_in, .data_oe_n_out, .ready_busy_out, .prog_mode_out);
